// ===== hw/sbc_ctrl_if.sv
// sbc_ctrl_if: control bits and events between the register file and line logic
// assumes: both ends on i_clock
`timescale 1ns/1ps
interface sbc_ctrl_if;
  logic sync_mode;
  logic polarity;
  logic wake_en;
  logic abd_en;
  logic rx_idle;
  logic wake_seen;
  logic abd_done;
  logic abd_ovf;
  modport regs (output sync_mode, output polarity, output wake_en, output abd_en,
                input rx_idle, input wake_seen, input abd_done, input abd_ovf);
  modport line (input sync_mode, input polarity, input wake_en, input abd_en,
                output rx_idle, output wake_seen, output abd_done, output abd_ovf);
endinterface

// ===== hw/sbc_line.sv
// sbc_line: receive-line watcher and transmit/clock pin polarity
// assumes: rx and status inputs synchronous to i_clock
`timescale 1ns/1ps
module sbc_line
  import sbc_pkg::*;
(
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_resetn,
  // control
  sbc_ctrl_if.line  ctl,
  // pins and status
  input  wire logic i_rx,
  input  wire logic i_rx_done,
  input  wire logic i_abd_timer_ovf,
  input  wire logic i_abd_complete,
  input  wire logic i_tx_data,
  input  wire logic i_sclk,
  output logic      o_tx_clock_pin,
  output logic      o_sample_edge
);
  sbc_rx_state_t state_ff;
  logic          rx_prev_ff;
  logic          sclk_prev_ff;
  logic          fall;

  assign fall = rx_prev_ff & ~i_rx;

  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
      rx_prev_ff <= 1'b1;
    else
      rx_prev_ff <= i_rx;

  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
      sclk_prev_ff <= 1'b0;
    else
      sclk_prev_ff <= i_sclk;

  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
      state_ff <= SBC_RX_IDLE;
    else
    begin
      unique case (state_ff)
        SBC_RX_IDLE:
          if (ctl.wake_en && !ctl.sync_mode)
            state_ff <= SBC_RX_WAKE;
          else if (fall)
            state_ff <= SBC_RX_BUSY;
        SBC_RX_BUSY:
          if (i_rx_done)
            state_ff <= SBC_RX_IDLE;
        SBC_RX_WAKE:
          // no character is assembled while waiting for the wake edge
          if (fall || !ctl.wake_en)
            state_ff <= SBC_RX_IDLE;
      endcase
    end

  assign ctl.rx_idle   = (state_ff != SBC_RX_BUSY);
  assign ctl.wake_seen = (state_ff == SBC_RX_WAKE) && fall;
  assign ctl.abd_done  = i_abd_complete && !ctl.sync_mode;
  assign ctl.abd_ovf   = i_abd_timer_ovf && !ctl.sync_mode;

  // async mode: optional inversion of transmit data
  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
      o_tx_clock_pin <= 1'b1;
    else
      o_tx_clock_pin <= ctl.sync_mode ? i_sclk : (i_tx_data ^ ctl.polarity);

  // sync mode: pick rising or falling serial clock edge for data
  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
      o_sample_edge <= 1'b0;
    else
      o_sample_edge <= ctl.sync_mode &&
        (ctl.polarity ? (i_sclk & ~sclk_prev_ff)
                      : (~i_sclk & sclk_prev_ff));

  ovf_gated_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    ctl.sync_mode |-> !ctl.abd_ovf) else $error("overflow seen in sync mode");
  idle_busy_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_ff == SBC_RX_IDLE && !(ctl.wake_en && !ctl.sync_mode) && fall)
      |=> !ctl.rx_idle) else $error("start bit did not clear idle");
  tx_invert_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !ctl.sync_mode |=> o_tx_clock_pin == ($past(i_tx_data) ^ $past(ctl.polarity)))
    else $error("transmit polarity wrong");
  rise_edge_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (ctl.sync_mode && ctl.polarity && $rose(i_sclk)) |=> o_sample_edge)
    else $error("rising edge missed");
  // pulse on a falling edge only, never on a rising one
  fall_edge_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (ctl.sync_mode && !ctl.polarity && $changed(i_sclk))
      |=> (o_sample_edge == !$past(i_sclk)))
    else $error("falling edge choice wrong");
  // waiting for the wake edge must never turn into a reception
  wake_nochar_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (state_ff == SBC_RX_WAKE) |=> ctl.rx_idle) else $error("reception while waiting wake");
endmodule

// ===== hw/sbc_pkg.sv
// sbc_pkg: shared constants for the serial baud control register block
// assumes: single 40 MHz clock domain, plain register port with 8-bit data
package sbc_pkg;
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;
  // register map
  localparam logic [1:0] ADDR_BAUD_CTRL = 2'h0;
  localparam logic [1:0] ADDR_IRQ_STAT  = 2'h1;
  localparam logic [1:0] ADDR_IRQ_MASK  = 2'h2;
  // baud_rate_control fields
  localparam int unsigned BIT_ABD_OVF  = 7;
  localparam int unsigned BIT_RX_IDLE  = 6;
  localparam int unsigned BIT_POLARITY = 4;
  localparam int unsigned BIT_WIDE_BRG = 3;
  localparam int unsigned BIT_WAKE_EN  = 1;
  localparam int unsigned BIT_ABD_EN   = 0;
  localparam logic [7:0] CTRL_WR_MASK  = 8'h1B;
  localparam logic [7:0] CTRL_RESET    = 8'h40;
  // interrupt status fields
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_RX_WAKE  = 0;
  localparam int unsigned IRQ_ABD_DONE = 1;
  localparam int unsigned IRQ_ABD_OVF  = 2;
  localparam logic [2:0] IRQ_ZERO      = 3'h0;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  typedef enum logic [1:0] { SBC_RX_IDLE, SBC_RX_BUSY, SBC_RX_WAKE } sbc_rx_state_t;
endpackage

// ===== hw/sbc_regs.sv
// sbc_regs: baud rate control register, interrupt status and mask
// assumes: read data returned one cycle after the read strobe, no wait states
`timescale 1ns/1ps
module sbc_regs
  import sbc_pkg::*;
(
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_resetn,
  // register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  // mode and control
  input  wire logic              i_sync_mode,
  sbc_ctrl_if.regs               ctl,
  output logic                   o_wide_brg,
  output logic                   o_rx_wake_flag,
  output logic                   o_irq
);
  logic [DATA_W-1:0] ctrl_ff;
  logic [IRQ_W-1:0]  stat_ff;
  logic [IRQ_W-1:0]  mask_ff;
  logic [IRQ_W-1:0]  events;
  logic              wr_ctrl;
  logic              ovf_ff;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  assign wr_ctrl = i_wr && hit(i_addr, ADDR_BAUD_CTRL);

  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
      ctrl_ff <= BYTE_ZERO;
    else
    begin
      if (wr_ctrl)
        ctrl_ff <= i_wdata & CTRL_WR_MASK;
      // hardware self-clears win over a same-cycle write
      if (ctl.wake_seen)
        ctrl_ff[BIT_WAKE_EN] <= 1'b0;
      if (ctl.abd_done)
        ctrl_ff[BIT_ABD_EN] <= 1'b0;
    end

  // overflow flag set by the timer and held while auto-baud is armed in async mode; cleared otherwise
  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
      ovf_ff <= 1'b0;
    else if (ctl.abd_ovf)
      ovf_ff <= 1'b1;
    else if (!ctl.abd_en || ctl.sync_mode)
      ovf_ff <= 1'b0;

  assign ctl.sync_mode = i_sync_mode;
  assign ctl.polarity  = ctrl_ff[BIT_POLARITY];
  assign ctl.wake_en   = ctrl_ff[BIT_WAKE_EN];
  assign ctl.abd_en    = ctrl_ff[BIT_ABD_EN];
  assign o_wide_brg    = ctrl_ff[BIT_WIDE_BRG];

  assign events[IRQ_RX_WAKE]  = ctl.wake_seen;
  assign events[IRQ_ABD_DONE] = ctl.abd_done;
  assign events[IRQ_ABD_OVF]  = ctl.abd_ovf;

  // a read clears status, but a same-cycle event still sets
  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
      stat_ff <= IRQ_ZERO;
    else if (i_rd && hit(i_addr, ADDR_IRQ_STAT))
      stat_ff <= events;
    else
      stat_ff <= stat_ff | events;

  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
      mask_ff <= IRQ_ZERO;
    else if (i_wr && hit(i_addr, ADDR_IRQ_MASK))
      mask_ff <= i_wdata[IRQ_W-1:0];

  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
      o_rx_wake_flag <= 1'b0;
    else
      o_rx_wake_flag <= ctl.wake_seen;

  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
      o_rdata <= BYTE_ZERO;
    else if (!i_rd)
      o_rdata <= BYTE_ZERO;
    else
      unique case (i_addr)
        ADDR_BAUD_CTRL:
        begin
          o_rdata                <= ctrl_ff & CTRL_WR_MASK;
          o_rdata[BIT_ABD_OVF]   <= ovf_ff;
          o_rdata[BIT_RX_IDLE]   <= ctl.rx_idle;
        end
        ADDR_IRQ_STAT: o_rdata <= {{(DATA_W-IRQ_W){1'b0}}, stat_ff};
        ADDR_IRQ_MASK: o_rdata <= {{(DATA_W-IRQ_W){1'b0}}, mask_ff};
        default:       o_rdata <= BYTE_ZERO;
      endcase

  assign o_irq = |(stat_ff & mask_ff);

  unimpl_zero_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_rd && hit(i_addr, ADDR_BAUD_CTRL)) |=> (o_rdata[5] == 1'b0 && o_rdata[2] == 1'b0))
    else $error("unimplemented bit read as one");
  abd_clear_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    ctl.abd_done |=> !ctrl_ff[BIT_ABD_EN]) else $error("autobaud enable did not clear");
  wake_clear_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    ctl.wake_seen |=> (!ctrl_ff[BIT_WAKE_EN] && o_rx_wake_flag))
    else $error("wake enable did not clear or flag not set");
  width_sel_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (wr_ctrl) |=> o_wide_brg == $past(i_wdata[BIT_WIDE_BRG]))
    else $error("generator width select wrong");
  // flag must survive until a read two cycles on, while auto-baud stays armed
  ovf_read_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (ctl.abd_ovf ##1 (ctl.abd_en && !ctl.sync_mode)
      ##1 (i_rd && hit(i_addr, ADDR_BAUD_CTRL))) |=> o_rdata[BIT_ABD_OVF])
    else $error("overflow flag not visible");
endmodule

// ===== hw/sbc_top.sv
// sbc_top: serial port baud rate control and status register block
// assumes: one 40 MHz clock, inputs synchronous, register port without wait
`timescale 1ns/1ps
module sbc_top
  import sbc_pkg::*;
(
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_resetn,
  // register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  // serial side
  input  wire logic              i_sync_mode,
  input  wire logic              i_rx,
  input  wire logic              i_rx_done,
  input  wire logic              i_abd_timer_ovf,
  input  wire logic              i_abd_complete,
  input  wire logic              i_tx_data,
  input  wire logic              i_sclk,
  output logic                   o_transmit_clock_pin,
  output logic                   o_sample_edge,
  output logic                   o_wide_baud_generator_select,
  output logic                   o_receive_interrupt_flag,
  output logic                   o_irq
);
  sbc_ctrl_if ctl ();

  sbc_regs u_regs (
    .i_clock        (i_clock),
    .i_resetn       (i_resetn),
    .i_addr         (i_addr),
    .i_wdata        (i_wdata),
    .i_wr           (i_wr),
    .i_rd           (i_rd),
    .o_rdata        (o_rdata),
    .i_sync_mode    (i_sync_mode),
    .ctl            (ctl),
    .o_wide_brg     (o_wide_baud_generator_select),
    .o_rx_wake_flag (o_receive_interrupt_flag),
    .o_irq          (o_irq)
  );

  sbc_line u_line (
    .i_clock         (i_clock),
    .i_resetn        (i_resetn),
    .ctl             (ctl),
    .i_rx            (i_rx),
    .i_rx_done       (i_rx_done),
    .i_abd_timer_ovf (i_abd_timer_ovf),
    .i_abd_complete  (i_abd_complete),
    .i_tx_data       (i_tx_data),
    .i_sclk          (i_sclk),
    .o_tx_clock_pin  (o_transmit_clock_pin),
    .o_sample_edge   (o_sample_edge)
  );
endmodule

// ===== testbench/sbc_peer.sv
// sbc_peer: behavioural far-side serial device for the baud control block
// assumes: driven through its tasks, every change just after i_clock rises
`timescale 1ns/1ps
module sbc_peer
(
  // clock
  input  wire logic i_clock,
  // line and status
  output logic      o_rx,
  output logic      o_rx_done,
  output logic      o_abd_timer_ovf,
  output logic      o_abd_complete,
  output logic      o_sclk
);
  // line idles high, serial clock stands low outside frames
  initial
  begin
    o_rx            = 1'b1;
    o_rx_done       = 1'b0;
    o_abd_timer_ovf = 1'b0;
    o_abd_complete  = 1'b0;
    o_sclk          = 1'b0;
  end
  task automatic start_bit();
    @(posedge i_clock);
    o_rx <= 1'b0;
  endtask
  task automatic finish_char();
    @(posedge i_clock);
    o_rx      <= 1'b1;
    o_rx_done <= 1'b1;
    @(posedge i_clock);
    o_rx_done <= 1'b0;
  endtask
  // kind 1 overflow, 2 auto-baud complete
  task automatic pulse(input int kind);
    @(posedge i_clock);
    o_abd_timer_ovf <= (kind == 1);
    o_abd_complete  <= (kind == 2);
    @(posedge i_clock);
    o_abd_timer_ovf <= 1'b0;
    o_abd_complete  <= 1'b0;
  endtask
  task automatic sclk_level(input logic v);
    @(posedge i_clock);
    o_sclk <= v;
  endtask
endmodule

// ===== testbench/serial_baud_control_reg_tb.sv
// serial_baud_control_reg_tb: self-checking bench for sbc_top
// assumes: sbc_pkg compiled first, sbc_peer drives the serial side
`timescale 1ns/1ps
module serial_baud_control_reg_tb
  import sbc_pkg::*;
;
  typedef struct { logic [7:0] wdata; logic [7:0] rdata; logic wide; } sbc_row_t;
  localparam int TIMEOUT = 4000;
  sbc_row_t rows [5] = '{'{8'hFF, 8'h5B, 1'b1}, '{8'h24, 8'h40, 1'b0},
    '{8'h08, 8'h48, 1'b1}, '{8'h13, 8'h53, 1'b0}, '{8'h00, 8'h40, 1'b0}};
  logic              i_clock;
  logic              i_resetn    = 1'b0;
  logic [ADDR_W-1:0] i_addr      = 2'h0;
  logic [DATA_W-1:0] i_wdata     = 8'h00;
  logic              i_wr        = 1'b0;
  logic              i_rd        = 1'b0;
  logic              i_sync_mode = 1'b0;
  logic              i_tx_data   = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  logic [DATA_W-1:0] rd_val;
  logic              rx, rx_done, ovf, cpl, sclk, pin, edge_pulse, wide, rx_flag, irq;
  int                mismatches  = 0;
  int                check_count = 0;
  int                cycles      = 0;
  int                edge_cnt    = 0;
  int                flag_cnt    = 0;
  int                e;
  sbc_top i_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_sync_mode(i_sync_mode), .i_rx(rx), .i_rx_done(rx_done),
    .i_abd_timer_ovf(ovf), .i_abd_complete(cpl), .i_tx_data(i_tx_data),
    .i_sclk(sclk), .o_transmit_clock_pin(pin), .o_sample_edge(edge_pulse),
    .o_wide_baud_generator_select(wide), .o_receive_interrupt_flag(rx_flag),
    .o_irq(irq));
  sbc_peer i_peer (.i_clock(i_clock), .o_rx(rx), .o_rx_done(rx_done),
    .o_abd_timer_ovf(ovf), .o_abd_complete(cpl), .o_sclk(sclk));
  initial
  begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  task automatic end_of_test();
    $display("mismatches=%0d check_count=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic reg_rd(input logic [1:0] a);
    @(posedge i_clock);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    #1 rd_val = o_rdata;
  endtask
  // pulses are counted on the falling edge, away from the launching edge
  always @(negedge i_clock)
  begin
    cycles++;
    if (edge_pulse === 1'b1) edge_cnt++;
    if (rx_flag === 1'b1) flag_cnt++;
    if (cycles == TIMEOUT)
    begin
      mismatches++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge i_clock);
    cmp8({7'h00, pin}, 8'h01);
    i_resetn <= 1'b1;
    reg_rd(ADDR_BAUD_CTRL);
    cmp8(rd_val, CTRL_RESET);
    foreach (rows[k])
    begin
      reg_wr(ADDR_BAUD_CTRL, rows[k].wdata);
      reg_rd(ADDR_BAUD_CTRL);
      cmp8(rd_val, rows[k].rdata);
      cmp8({7'h00, wide}, {7'h00, rows[k].wide});
    end
    for (int p = 0; p < 2; p++)
    begin
      reg_wr(ADDR_BAUD_CTRL, p[0] ? 8'h10 : 8'h00);
      for (int v = 0; v < 2; v++)
      begin
        @(posedge i_clock);
        i_tx_data <= v[0];
        repeat (3) @(posedge i_clock);
        #1 cmp8({7'h00, pin}, {7'h00, v[0] ^ p[0]});
      end
    end
    reg_wr(ADDR_IRQ_MASK, 8'h07);
    i_peer.start_bit();
    reg_rd(ADDR_BAUD_CTRL);
    cmp8(rd_val, 8'h10);
    i_peer.finish_char();
    reg_rd(ADDR_BAUD_CTRL);
    cmp8(rd_val, 8'h50);
    reg_wr(ADDR_BAUD_CTRL, 8'h02);
    e = flag_cnt;
    i_peer.start_bit();
    repeat (4) @(posedge i_clock);
    cmp8(8'(flag_cnt - e), 8'h01);
    reg_rd(ADDR_BAUD_CTRL);
    cmp8(rd_val & CTRL_WR_MASK, 8'h00);
    i_peer.finish_char();
    cmp8({7'h00, irq}, 8'h01);
    reg_rd(ADDR_IRQ_STAT);
    cmp8(rd_val, 8'h01);
    reg_wr(ADDR_BAUD_CTRL, 8'h01);
    i_peer.pulse(1);
    reg_rd(ADDR_BAUD_CTRL);
    cmp8(rd_val, 8'hC1);
    i_peer.pulse(2);
    reg_rd(ADDR_BAUD_CTRL);
    cmp8(rd_val, 8'h40);
    reg_rd(ADDR_IRQ_STAT);
    cmp8(rd_val, 8'h06);
    cmp8({7'h00, irq}, 8'h00);
    reg_wr(ADDR_IRQ_MASK, 8'h00);
    reg_wr(ADDR_BAUD_CTRL, 8'h01);
    i_peer.pulse(2);
    repeat (2) @(posedge i_clock);
    cmp8({7'h00, irq}, 8'h00);
    reg_rd(ADDR_IRQ_STAT);
    cmp8(rd_val, 8'h02);
    @(posedge i_clock);
    i_sync_mode <= 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      reg_wr(ADDR_BAUD_CTRL, p[0] ? 8'h10 : 8'h00);
      e = edge_cnt;
      i_peer.sclk_level(1'b1);
      repeat (4) @(posedge i_clock);
      cmp8(8'(edge_cnt - e), {7'h00, p[0]});
      cmp8({7'h00, pin}, 8'h01);
      i_peer.sclk_level(1'b0);
      repeat (4) @(posedge i_clock);
      cmp8(8'(edge_cnt - e), 8'h01);
      cmp8({7'h00, pin}, 8'h00);
    end
    reg_wr(2'h3, 8'hFF);
    reg_rd(2'h3);
    cmp8(rd_val, 8'h00);
    reg_rd(ADDR_BAUD_CTRL);
    cmp8(rd_val & CTRL_WR_MASK, 8'h10);
    // mid-run reset with every control bit set must bring them all back
    reg_wr(ADDR_BAUD_CTRL, 8'h1B);
    @(posedge i_clock);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clock);
    cmp8({7'h00, pin}, 8'h01);
    i_resetn <= 1'b1;
    reg_rd(ADDR_BAUD_CTRL);
    cmp8(rd_val, CTRL_RESET);
    cmp8({7'h00, wide}, 8'h00);
    reg_rd(ADDR_IRQ_MASK);
    cmp8(rd_val, 8'h00);
    end_of_test();
  end
endmodule
